// >>> sfp_ctrl.sv
// Purpose: host controller driving a parallel sector-programmed flash
// Assumes: 25 MHz clk_i; flash data pins sampled through three flops
// Notes: command words are parameters; device write time is a parameter
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE_01: issue the three-word unlock sequence before any sector word load.
// RULE_02: load all 128 words of the sector in every program operation; a starved source ends the load early with error_o set.
// RULE_03: start each next word load within the 150 us load window.
// RULE_04: keep address bits 15 to 7 on the sector for every load strobe.
// RULE_05: unloaded sector words read indeterminate afterwards.
// RULE_06: device relocks after each program cycle.
// RULE_07: command data use bits 7..0, command addresses bits 14..0.
// RULE_08: device flips toggle status on each output-enable or select toggle.
// RULE_09: toggle status on bits 6 and 14; first and last reads undefined.
// RULE_10: toggle polling keeps one fixed address for the whole poll.
// RULE_11: id mode returns maker code at address 0, device code at 1.
// RULE_12: device leaves id mode on power loss.
// RULE_13: id exit sequence restores normal array reads.
// RULE_14: read with select and output enable low; outputs float otherwise.
// RULE_15: while programming, polled bits read inverted until done.
// RULE_16: load window expiry starts the erase-then-program cycle.
module sfp_ctrl
  import sfp_pkg::*;
#(
  parameter int WC_LIMIT = WC_CYC,
  parameter logic [15:0] CMD_ADDR_A = 16'h5555,
  parameter logic [15:0] CMD_ADDR_B = 16'h2aaa,
  parameter logic [15:0] CMD_DATA_A = 16'h00aa,
  parameter logic [15:0] CMD_DATA_B = 16'h0055,
  parameter logic [15:0] CMD_PROG = 16'h00a0,
  parameter logic [15:0] CMD_ID_IN = 16'h0090,
  parameter logic [15:0] CMD_ID_OUT = 16'h00f0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [1:0] cmd_op_i,
  input wire logic [15:0] cmd_addr_i,
  input wire logic poll_data_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [15:0] wr_data_i,
  output logic done_o,
  output logic error_o,
  output logic [15:0] rdata_o,
  output logic [15:0] id_dev_o,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic [15:0] addr_o,
  output logic [15:0] dq_o,
  output logic dq_oe_o,
  input wire logic [15:0] dq_i
);
  localparam int LOAD_GAP = WLC_CYC - WP_CYC - WPH_CYC;
  initial begin
    if (WC_LIMIT < 1 || WC_LIMIT > 1048575) $error("sfp_ctrl: WC_LIMIT");
    if (LOAD_GAP < 1) $error("sfp_ctrl: clock too slow for load window");
    if (CMD_ADDR_A[15] || CMD_ADDR_B[15]) $error("sfp_ctrl: command address");
  end
  sfp_bus_t bus_r, bus_nxt;
  sfp_phase_t ph_r, ph_nxt;
  logic [1:0] op_r, op_nxt;
  logic [1:0] step_r, step_nxt;
  logic [7:0] idx_r, idx_nxt;
  logic [7:0] tcnt_r, tcnt_nxt;
  logic [19:0] wcnt_r, wcnt_nxt;
  logic [8:0] sect_r, sect_nxt;
  logic [15:0] last_r, last_nxt;
  logic [15:0] prev_r, prev_nxt;
  logic first_r, first_nxt;
  logic pdata_r, pdata_nxt;
  logic [15:0] rd_r, rd_nxt, rdata_nxt, iddev_nxt;
  logic done_nxt, error_nxt;
  logic ce_nxt, oe_nxt, we_nxt, dqoe_nxt;
  logic [15:0] addr_nxt, dq_nxt;
  logic [15:0] s1_r, s2_r, s3_r;
  logic fifo_valid, fifo_ready;
  logic [15:0] fifo_data;

  sfp_buf #(.WIDTH(16)) u_buf (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(wr_valid_i),
    .in_ready_o(wr_ready_o),
    .in_data_i(wr_data_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_ready),
    .out_data_o(fifo_data)
  );

  function automatic logic [15:0] cmd_word(input logic [1:0] st,
                                           input logic [15:0] third);
    cmd_word = (st == 2'h0) ? CMD_DATA_A :
               (st == 2'h1) ? CMD_DATA_B : third;
  endfunction
  function automatic logic [15:0] cmd_adr(input logic [1:0] st);
    cmd_adr = (st == 2'h1) ? CMD_ADDR_B : CMD_ADDR_A;
  endfunction

  assign cmd_ready_o = (bus_r == BUS_IDLE);
  assign fifo_ready = (bus_r == BUS_FETCH);

  always_comb begin
    bus_nxt = bus_r;
    ph_nxt = ph_r;
    op_nxt = op_r;
    step_nxt = step_r;
    idx_nxt = idx_r;
    tcnt_nxt = tcnt_r;
    wcnt_nxt = wcnt_r;
    sect_nxt = sect_r;
    last_nxt = last_r;
    prev_nxt = prev_r;
    first_nxt = first_r;
    pdata_nxt = pdata_r;
    rd_nxt = rd_r;
    rdata_nxt = rdata_o;
    iddev_nxt = id_dev_o;
    done_nxt = 1'b0;
    error_nxt = error_o;
    ce_nxt = ce_n_o;
    oe_nxt = oe_n_o;
    we_nxt = we_n_o;
    dqoe_nxt = dq_oe_o;
    addr_nxt = addr_o;
    dq_nxt = dq_o;
    if (ph_r == PH_POLL) begin
      wcnt_nxt = wcnt_r + 20'h1;
    end
    case (bus_r)
      BUS_IDLE: begin
        if (cmd_valid_i) begin
          op_nxt = cmd_op_i;
          sect_nxt = cmd_addr_i[15:SECTOR_LSB];
          pdata_nxt = poll_data_i;
          error_nxt = 1'b0;
          step_nxt = 2'h0;
          idx_nxt = 8'h0;
          if (cmd_op_i == OP_READ) begin
            ph_nxt = PH_READ;
            bus_nxt = BUS_RLO;
            addr_nxt = cmd_addr_i;
            tcnt_nxt = 8'(RD_CYC + 1);
          end else begin
            // unlock words first, for program and for id entry [RULE_01]
            ph_nxt = PH_CMD;
            bus_nxt = BUS_WLO;
            addr_nxt = cmd_adr(2'h0); // [RULE_07]
            dq_nxt = CMD_DATA_A; // [RULE_07]
            tcnt_nxt = 8'(WP_CYC - 1);
          end
        end
      end
      BUS_FETCH: begin
        wcnt_nxt = wcnt_r + 20'h1;
        if (fifo_valid) begin
          bus_nxt = BUS_WLO;
          addr_nxt = {sect_r, idx_r[6:0]}; // [RULE_04]
          dq_nxt = fifo_data;
          last_nxt = fifo_data;
          tcnt_nxt = 8'(WP_CYC - 1);
        end else if (wcnt_r >= 20'(LOAD_GAP - 1)) begin
          // source starved: the device will start programming anyway
          error_nxt = 1'b1; // [RULE_03]
          ph_nxt = PH_POLL;
          bus_nxt = BUS_RLO;
          wcnt_nxt = 20'h0;
          first_nxt = 1'b1;
          addr_nxt = {sect_r, 7'h0};
          tcnt_nxt = 8'(RD_CYC + 1);
        end
      end
      BUS_WLO: begin
        if (tcnt_r == 8'h0) begin
          bus_nxt = BUS_WHI;
          tcnt_nxt = 8'(WPH_CYC - 1);
        end else begin
          tcnt_nxt = tcnt_r - 8'h1;
        end
      end
      BUS_WHI: begin
        if (tcnt_r != 8'h0) begin
          tcnt_nxt = tcnt_r - 8'h1;
        end else if (ph_r == PH_LOAD) begin
          idx_nxt = idx_r + 8'h1;
          wcnt_nxt = 20'h0;
          if (idx_r == 8'(SECTOR_WORDS - 1)) begin
            ph_nxt = PH_POLL; // [RULE_02]
            bus_nxt = BUS_RLO;
            first_nxt = 1'b1;
            tcnt_nxt = 8'(RD_CYC + 1);
          end else begin
            bus_nxt = BUS_FETCH; // [RULE_03]
          end
        end else if (step_r != 2'(CMD_STEPS - 1)) begin
          step_nxt = step_r + 2'h1;
          bus_nxt = BUS_WLO;
          addr_nxt = cmd_adr(step_r + 2'h1); // [RULE_07]
          dq_nxt = cmd_word(step_r + 2'h1, (ph_r == PH_EXIT) ? CMD_ID_OUT :
                   (op_r == OP_PROG) ? CMD_PROG : CMD_ID_IN); // [RULE_07]
          tcnt_nxt = 8'(WP_CYC - 1);
        end else if (ph_r == PH_EXIT) begin
          bus_nxt = BUS_IDLE; // [RULE_13]
          done_nxt = 1'b1;
        end else if (op_r == OP_PROG) begin
          ph_nxt = PH_LOAD; // [RULE_01]
          bus_nxt = BUS_FETCH;
          wcnt_nxt = 20'h0;
        end else begin
          ph_nxt = PH_IDRD;
          step_nxt = 2'h0;
          bus_nxt = BUS_RLO;
          addr_nxt = 16'h0000;
          tcnt_nxt = 8'(RD_CYC + 1);
        end
      end
      BUS_RLO: begin
        // extra two cycles cover the three-flop pin sampler
        if (tcnt_r != 8'h0) begin
          tcnt_nxt = tcnt_r - 8'h1;
        end else if (s2_r == s3_r) begin
          rd_nxt = s3_r;
          bus_nxt = BUS_RHI;
          tcnt_nxt = 8'(OEHP_CYC - 1);
        end
      end
      BUS_RHI: begin
        if (tcnt_r != 8'h0) begin
          tcnt_nxt = tcnt_r - 8'h1;
        end else begin
          case (ph_r)
            PH_READ: begin
              rdata_nxt = rd_r;
              done_nxt = 1'b1;
              bus_nxt = BUS_IDLE;
            end
            PH_IDRD: begin
              if (step_r == 2'h0) begin
                rdata_nxt = rd_r;
                step_nxt = 2'h1;
                bus_nxt = BUS_RLO;
                addr_nxt = 16'h0001;
                tcnt_nxt = 8'(RD_CYC + 1);
              end else begin
                iddev_nxt = rd_r;
                ph_nxt = PH_EXIT;
                step_nxt = 2'h0;
                bus_nxt = BUS_WLO;
                addr_nxt = cmd_adr(2'h0);
                dq_nxt = CMD_DATA_A;
                tcnt_nxt = 8'(WP_CYC - 1);
              end
            end
            default: begin
              // poll at one fixed address until the status settles
              prev_nxt = rd_r;
              first_nxt = 1'b0;
              if ((pdata_r && rd_r[POLL_LO] == last_r[POLL_LO] &&
                   rd_r[POLL_HI] == last_r[POLL_HI]) ||
                  (!pdata_r && !first_r &&
                   rd_r[TOG_LO] == prev_r[TOG_LO] &&
                   rd_r[TOG_HI] == prev_r[TOG_HI])) begin
                done_nxt = 1'b1;
                bus_nxt = BUS_IDLE;
              end else if (wcnt_r >= 20'(WC_LIMIT)) begin
                error_nxt = 1'b1;
                done_nxt = 1'b1;
                bus_nxt = BUS_IDLE;
              end else begin
                bus_nxt = BUS_RLO; // [RULE_10]
                tcnt_nxt = 8'(RD_CYC + 1);
              end
            end
          endcase
        end
      end
      default: begin
        bus_nxt = BUS_IDLE;
      end
    endcase
    ce_nxt = !(bus_nxt == BUS_WLO || bus_nxt == BUS_WHI ||
               bus_nxt == BUS_RLO);
    oe_nxt = (bus_nxt != BUS_RLO);
    we_nxt = (bus_nxt != BUS_WLO);
    dqoe_nxt = (bus_nxt == BUS_WLO || bus_nxt == BUS_WHI);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bus_r <= BUS_IDLE;
      ph_r <= PH_CMD;
      op_r <= OP_READ;
      step_r <= 2'h0;
      idx_r <= 8'h0;
      tcnt_r <= 8'h0;
      wcnt_r <= 20'h0;
      sect_r <= 9'h0;
      last_r <= 16'h0;
      prev_r <= 16'h0;
      first_r <= 1'b1;
      pdata_r <= 1'b0;
      rd_r <= 16'h0;
      rdata_o <= 16'h0;
      id_dev_o <= 16'h0;
      done_o <= 1'b0;
      error_o <= 1'b0;
      ce_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      we_n_o <= 1'b1;
      dq_oe_o <= 1'b0;
      addr_o <= 16'h0;
      dq_o <= 16'h0;
      s1_r <= 16'h0;
      s2_r <= 16'h0;
      s3_r <= 16'h0;
    end else begin
      bus_r <= bus_nxt;
      ph_r <= ph_nxt;
      op_r <= op_nxt;
      step_r <= step_nxt;
      idx_r <= idx_nxt;
      tcnt_r <= tcnt_nxt;
      wcnt_r <= wcnt_nxt;
      sect_r <= sect_nxt;
      last_r <= last_nxt;
      prev_r <= prev_nxt;
      first_r <= first_nxt;
      pdata_r <= pdata_nxt;
      rd_r <= rd_nxt;
      rdata_o <= rdata_nxt;
      id_dev_o <= iddev_nxt;
      done_o <= done_nxt;
      error_o <= error_nxt;
      ce_n_o <= ce_nxt;
      oe_n_o <= oe_nxt;
      we_n_o <= we_nxt;
      dq_oe_o <= dqoe_nxt;
      addr_o <= addr_nxt;
      dq_o <= dq_nxt;
      s1_r <= dq_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_cmd_strobe;
    $fell(we_n_o) && ph_r == PH_CMD;
  endsequence
  sequence s_load_strobe;
    $fell(we_n_o) && ph_r == PH_LOAD;
  endsequence

  property p_unlock_first;
    s_cmd_strobe |-> step_r != 2'h0 || (addr_o == CMD_ADDR_A &&
                                         dq_o == CMD_DATA_A);
  endproperty
  a_unlock_first: assert property (p_unlock_first) // [RULE_01]
    else $error("first unlock word wrong");
  property p_full_sector;
    $rose(ph_r == PH_POLL) && !error_o |-> idx_r == 8'(SECTOR_WORDS);
  endproperty
  a_full_sector: assert property (p_full_sector) // [RULE_02]
    else $error("poll began before a full sector");
  property p_window;
    bus_r == BUS_FETCH |-> wcnt_r < 20'(LOAD_GAP);
  endproperty
  a_window: assert property (p_window) // [RULE_03]
    else $error("word load window exceeded");
  property p_sector_hold;
    s_load_strobe |-> addr_o[15:SECTOR_LSB] == sect_r ##1
      (!we_n_o)[*4];
  endproperty
  a_sector_hold: assert property (p_sector_hold) // [RULE_04]
    else $error("load strobe off sector or too short");
  property p_cmd_format;
    s_cmd_strobe |-> dq_o[15:8] == 8'h00 && !addr_o[15];
  endproperty
  a_cmd_format: assert property (p_cmd_format) // [RULE_07]
    else $error("command word out of format");
  property p_poll_addr;
    $fell(oe_n_o) && ph_r == PH_POLL && !first_r |-> $stable(addr_o);
  endproperty
  a_poll_addr: assert property (p_poll_addr) // [RULE_10]
    else $error("poll address moved");
endmodule // sfp_ctrl
`default_nettype wire

// >>> sfp_pkg.sv
// Purpose: shared constants for the sector flash program controller
// Assumes: one 25 MHz clock; times below are as printed, cycles derived
// Notes: cycle counts round up for least times and down for longest times
package sfp_pkg;
  localparam int CLK_NS = 40;
  localparam int WP_NS = 200;
  localparam int WPH_NS = 200;
  localparam int OEHP_NS = 150;
  localparam int RD_NS = 250;
  localparam int WLC_US = 150;
  localparam int WC_MS = 20;
  localparam int WP_CYC = (WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WPH_CYC = (WPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int OEHP_CYC = (OEHP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC = (RD_NS + CLK_NS - 1) / CLK_NS;
  localparam int WLC_CYC = (WLC_US * 1000) / CLK_NS;
  localparam int WC_CYC = (WC_MS * 1000000) / CLK_NS;
  localparam int SECTOR_WORDS = 128;
  localparam int SECTOR_LSB = 7;
  localparam int CMD_STEPS = 3;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_PROG = 2'h1;
  localparam logic [1:0] OP_ID = 2'h2;
  localparam int TOG_LO = 6;
  localparam int TOG_HI = 14;
  localparam int POLL_LO = 7;
  localparam int POLL_HI = 15;
  typedef enum logic [5:0] {
    BUS_IDLE = 6'h01, BUS_WLO = 6'h02, BUS_WHI = 6'h04,
    BUS_RLO = 6'h08, BUS_RHI = 6'h10, BUS_FETCH = 6'h20
  } sfp_bus_t;
  typedef enum logic [5:0] {
    PH_CMD = 6'h01, PH_LOAD = 6'h02, PH_POLL = 6'h04,
    PH_IDRD = 6'h08, PH_EXIT = 6'h10, PH_READ = 6'h20
  } sfp_phase_t;
endpackage

// >>> sfp_buf.sv
// Purpose: two-entry valid/ready buffer in the program data path
// Assumes: single clock, synchronous active-low reset
// Notes: read data come from the entry registers
`timescale 1ns/1ps
`default_nettype none
module sfp_buf #(
  parameter int WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  initial begin
    if (WIDTH < 1) $error("sfp_buf: WIDTH must be positive");
  end
  logic [WIDTH-1:0] mem_r [2];
  logic [WIDTH-1:0] mem_nxt [2];
  logic wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic push, pop;
  assign in_ready_o = (cnt_r != 2'h2);
  assign out_valid_o = (cnt_r != 2'h0);
  assign out_data_o = mem_r[rp_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_comb begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wp_r] = in_data_i;
      wp_nxt = ~wp_r;
    end
    if (pop) begin
      rp_nxt = ~rp_r;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
      mem_r[0] <= '0;
      mem_r[1] <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      mem_r <= mem_nxt;
    end
  end
endmodule // sfp_buf
`default_nettype wire

// >>> sfp_flash_model.sv
// Purpose: behavioural model of the sector-programmed parallel flash
// Assumes: write strobes come from the controller, no clock in the device
// Notes: a read during word loading, once a word is loaded, closes the load phase at once
`timescale 1ns/1ps
`default_nettype none
module sfp_flash_model
  import sfp_pkg::*;
#(
  parameter logic [15:0] MAKER_CODE = 16'h00c3, // arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h0042, // arbitrary value
  parameter int PROG_NS = 8000,
  parameter int WLC_NS = 150000
) (
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic fault_o
);
  logic [15:0] mem [0:65535];
  logic [15:0] lat [0:127];
  logic [127:0] got;
  logic [15:0] wa, last_d, held, rd_val, poll_a;
  logic [8:0] sect;
  logic [1:0] step;
  logic loading, busy, idm, tog, poll_on;
  time last_t;
  wire logic rd_n;
  assign rd_n = ce_n_i | oe_n_i | ~we_n_i;
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 16'hffff;
    {step, loading, busy, tog, fault_o, got, poll_on} = '0;
    idm = 1'b0;
    {held, last_d, sect, wa, poll_a} = '0;
    last_t = 0;
  end
  task automatic start_prog();
    loading = 1'b0;
    busy = 1'b1;
    fork
      begin
        #(PROG_NS);
        for (int i = 0; i < 128; i++)
          mem[{sect, i[6:0]}] = got[i] ? lat[i] :
                                ~mem[{sect, i[6:0]}];
        got = '0;
        busy = 1'b0;
        poll_on = 1'b0;
        step = 2'h0;
      end
    join_none
  endtask
  // strobes and address move on one controller edge; let them settle first
  always @(negedge we_n_i) begin
    #1;
    if (!ce_n_i) wa = addr_i;
  end
  always @(posedge we_n_i) begin
    if (!ce_n_i && !busy) begin
      if (loading) begin
        if (got != '0 && wa[15:7] != sect) fault_o = 1'b1;
        sect = wa[15:7];
        lat[wa[6:0]] = dq_i;
        got[wa[6:0]] = 1'b1;
        last_d = dq_i;
        last_t = $time;
      end else if (step == 2'h0) begin
        step = (wa[14:0] == 15'h5555 && dq_i[7:0] == 8'haa) ? 2'h1 :
               2'h0;
      end else if (step == 2'h1) begin
        step = (wa[14:0] == 15'h2aaa && dq_i[7:0] == 8'h55) ? 2'h2 :
               2'h0;
      end else begin
        step = 2'h0;
        if (wa[14:0] == 15'h5555 && dq_i[7:0] == 8'ha0)
          loading = 1'b1;
        if (wa[14:0] == 15'h5555 && dq_i[7:0] == 8'h90)
          idm = 1'b1;
        if (wa[14:0] == 15'h5555 && dq_i[7:0] == 8'hf0)
          idm = 1'b0;
      end
    end
  end
  always #100
    if (loading && got != '0 && $time - last_t > WLC_NS)
      start_prog();
  always @(negedge rd_n) begin
    #1;
    if (loading && got != '0) start_prog();
    if (busy && poll_on && addr_i != poll_a) fault_o = 1'b1;
    if (busy) poll_a = addr_i;
    poll_on = busy;
  end
  always_comb begin
    rd_val = mem[addr_i];
    if (idm && addr_i[15:1] == 15'h0)
      rd_val = addr_i[0] ? DEV_CODE : MAKER_CODE;
    if (busy) begin
      rd_val = last_d;
      rd_val[POLL_HI] = ~last_d[POLL_HI];
      rd_val[POLL_LO] = ~last_d[POLL_LO];
      rd_val[TOG_HI] = tog;
      rd_val[TOG_LO] = tog;
    end
  end
  always @(posedge rd_n) begin
    held <= rd_val;
    if (busy) tog <= ~tog;
  end
  // released pins show the inverse of the last value, never a settled x
  assign dq_o = rd_n ? ~held : rd_val;
endmodule // sfp_flash_model
`default_nettype wire

// >>> sector_flash_program_control_tb.sv
// Purpose: self-checking bench for the sector flash program controller
// Assumes: flash model on the pins, inputs driven on the falling edge
// Notes: poll timeout shortened to 2000 cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin \
  mismatches++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, b); \
end end
module sector_flash_program_control_tb;
  import sfp_pkg::*;
  localparam logic [15:0] MAKER_CODE = 16'h00c3; // arbitrary value
  localparam logic [15:0] DEV_CODE = 16'h0042; // arbitrary value
  typedef struct packed {
    logic [1:0] op;
    logic [15:0] rd;
    logic [15:0] id;
    logic err;
  } sfp_exp_t;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cmd_valid_i, poll_data_i, wr_valid_i;
  logic [1:0] cmd_op_i;
  logic [15:0] cmd_addr_i, wr_data_i;
  logic cmd_ready_o, wr_ready_o, done_o, error_o, ce_n_o, oe_n_o, we_n_o;
  logic dq_oe_o, fault;
  logic [15:0] rdata_o, id_dev_o, addr_o, dq_o, flash_q;
  wire logic [15:0] bus;
  int mismatches = 0;
  int checked = 0;
  logic [31:0] seed = 32'hb4079f25;
  sfp_exp_t exp_q[$];
  logic [15:0] img [logic [15:0]];
  logic [15:0] rb [0:6] = '{16'h0a80, 16'h0aff, 16'h0b00, 16'h0b7f,
                            16'h0c00, 16'h0c09, 16'h0a7f};
  assign bus = dq_oe_o ? dq_o : flash_q;
  always #20 clk_i = ~clk_i;
  sfp_ctrl #(.WC_LIMIT(2000)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i), .poll_data_i(poll_data_i),
    .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o), .wr_data_i(wr_data_i),
    .done_o(done_o), .error_o(error_o), .rdata_o(rdata_o),
    .id_dev_o(id_dev_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o),
    .addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dq_i(bus));
  sfp_flash_model #(.MAKER_CODE(MAKER_CODE), .DEV_CODE(DEV_CODE)) i_flash (
    .ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o), .addr_i(addr_o),
    .dq_i(bus), .dq_o(flash_q), .fault_o(fault));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wrap_up();
    if (mismatches == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic run_cmd(input logic [1:0] op, input logic [15:0] a,
                         input logic pd, input logic err);
    int n;
    logic [15:0] rd;
    rd = (op == OP_ID) ? MAKER_CODE : (img.exists(a) ? img[a] : 16'hffff);
    exp_q.push_back('{op, rd, DEV_CODE, err});
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 100) begin
      mismatches++;
      wrap_up();
    end
    cmd_op_i = op;
    cmd_addr_i = a;
    poll_data_i = pd;
    cmd_valid_i = 1'b1;
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 20000) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 20000) begin
      mismatches++;
      wrap_up();
    end
    @(negedge clk_i);
  endtask
  // words come with random gaps; the slow drain still fills the buffer
  task automatic feed(input logic [15:0] base, input int cnt);
    int n;
    for (int i = 0; i < cnt; i++) begin
      seed = lfsr(seed);
      if (seed[0]) begin
        wr_valid_i = 1'b0;
        @(negedge clk_i);
      end
      img[base | i[15:0]] = seed[31:16];
      wr_data_i = seed[31:16];
      wr_valid_i = 1'b1;
      n = 0;
      while (wr_ready_o !== 1'b1 && n < 100) begin
        @(negedge clk_i);
        n++;
      end
      if (n == 100) begin
        mismatches++;
        wrap_up();
      end
      @(negedge clk_i);
    end
    wr_valid_i = 1'b0;
  endtask
  always @(negedge clk_i) begin
    sfp_exp_t e;
    if (rst_n_i && done_o === 1'b1) begin
      `CHK(exp_q.size() > 0, 1'b1)
      if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        `CHK(error_o, e.err)
        if (e.op != OP_PROG) `CHK(rdata_o, e.rd)
        if (e.op == OP_ID) `CHK(id_dev_o, e.id)
      end
    end
  end
  initial begin
    {cmd_valid_i, poll_data_i, wr_valid_i} = '0;
    cmd_op_i = OP_READ;
    cmd_addr_i = 16'h0;
    wr_data_i = 16'h0;
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    run_cmd(OP_READ, 16'h1234, 1'b0, 1'b0);
    run_cmd(OP_ID, 16'h0000, 1'b0, 1'b0);
    run_cmd(OP_READ, 16'h0001, 1'b0, 1'b0);
    fork
      feed(16'h0a80, 128);
      run_cmd(OP_PROG, 16'h0a80, 1'b1, 1'b0);
    join
    fork
      feed(16'h0b00, 128);
      run_cmd(OP_PROG, 16'h0b00, 1'b0, 1'b0);
    join
    fork
      feed(16'h0c00, 10);
      run_cmd(OP_PROG, 16'h0c00, 1'b0, 1'b1);
    join
    for (int i = 0; i < 7; i++)
      run_cmd(OP_READ, rb[i], 1'b0, 1'b0);
    `CHK(fault, 1'b0)
    wrap_up();
  end
endmodule // sector_flash_program_control_tb
`default_nettype wire
